// ### rtl/srbm_consts.svh
// timing constants for the supervisor reset and battery monitor
`ifndef SRBM_CONSTS_SVH
`define SRBM_CONSTS_SVH

`define SRBM_CLK_MHZ            250
// reset input glitch filter, ns
`define SRBM_REJECT_NS          50
`define SRBM_MIN_PULSE_NS       200
// chosen fixed filter threshold, ns, between the two limits above
`define SRBM_FILTER_NS          100
`define SRBM_FILTER_CYC         ((`SRBM_FILTER_NS * `SRBM_CLK_MHZ + 999) / 1000)
// reset release delay, ms
`define SRBM_RELEASE_MIN_MS     40
`define SRBM_RELEASE_MAX_MS     200
`define SRBM_RELEASE_MS         100
`define SRBM_RELEASE_CYC        (64'(`SRBM_RELEASE_MS) * 64'(`SRBM_CLK_MHZ) * 64'd1000)
// battery test interval, hours
`define SRBM_TEST_HOURS         24
`define SRBM_TEST_CYC           (64'(`SRBM_TEST_HOURS) * 64'd3600 * \
                                 64'(`SRBM_CLK_MHZ) * 64'd1000000)
`define SRBM_CNT_W              48
`define SRBM_FILT_W             8

`endif

// ### rtl/srbm_pkg.sv
// types for the supervisor reset and battery monitor
`default_nettype none
package srbm_pkg;
    typedef enum logic [1:0] {
        SRBM_BACKUP,
        SRBM_RECOVER,
        SRBM_RUN
    } srbm_pwr_t;
endpackage : srbm_pkg
`default_nettype wire

// ### rtl/srbm_sync.sv
// two-stage synchroniser for asynchronous level inputs
`default_nettype none
module srbm_sync (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic rst_val,
    input  wire logic d,
    output var  logic q
);
    // ****************************************
    // two stages, idle level until primed
    // ****************************************
    typedef struct packed {
        logic       meta;
        logic       hold;
        logic [1:0] primed;
    } srbm_sync_t;

    srbm_sync_t st_ff;
    srbm_sync_t nxt_st;

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.meta   = d;
        nxt_st.hold   = st_ff.meta;
        nxt_st.primed = {st_ff.primed[0], 1'b1};
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // reset-time stage contents are not pin data: show rst_val until both stages are filled
    assign q = st_ff.primed[1] ? st_ff.hold : rst_val;
endmodule : srbm_sync
`default_nettype wire

// ### rtl/srbm_top.sv
// supervisor: reset filter and stretch, battery test, power-fail output
`default_nettype none
`include "srbm_consts.svh"

// Contract
// - ignore reset low pulses under 50 ns
// - reset held 40 to 200 ms after release
// - test battery at power-up, then every 24h
// - battery below 2.5V asserts battery-low flag
// - battery-low stays until a later test passes
// - no battery tests while on backup
// - fail output tracks sense when comparator enabled
// - backup disables comparator, fail output low
// - recovery holds fail output high, then tracks
// - supply return holds reset for recovery time
// - external reset equals power-cycle reset; here no battery test or test timer restart follows it
module srbm_top
    import srbm_pkg::*;
#(
    parameter logic [`SRBM_CNT_W-1:0] RELEASE_CYC = `SRBM_CNT_W'(`SRBM_RELEASE_CYC),
    parameter logic [`SRBM_CNT_W-1:0] TEST_CYC    = `SRBM_CNT_W'(`SRBM_TEST_CYC)
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic external_reset_request_n,
    input  wire logic supply_sense_input,
    input  wire logic supply_above_deselect,
    input  wire logic battery_ok,
    output var  logic reset_out_n_o,
    output var  logic reset_out_n_oe,
    output var  logic battery_low_flag_n_o,
    output var  logic battery_low_flag_n_oe,
    output var  logic supply_fail_output_n,
    output var  logic battery_test_pulse
);
    localparam logic [`SRBM_FILT_W-1:0] FILTER_CYC = `SRBM_FILT_W'(`SRBM_FILTER_CYC);
    localparam logic [`SRBM_CNT_W-1:0]  CNT_ONE    = `SRBM_CNT_W'(1);

    // ****************************************
    // counter helpers
    // ****************************************
    function automatic logic [`SRBM_CNT_W-1:0] cnt_step(
        input logic [`SRBM_CNT_W-1:0] cnt
    );
        return cnt + CNT_ONE;
    endfunction : cnt_step

    function automatic logic cnt_last(
        input logic [`SRBM_CNT_W-1:0] cnt,
        input logic [`SRBM_CNT_W-1:0] lim
    );
        return cnt >= lim - CNT_ONE;
    endfunction : cnt_last

    // ****************************************
    // state record
    // ****************************************
    typedef struct packed {
        srbm_pwr_t                 pwr;
        logic [`SRBM_FILT_W-1:0]   filt_cnt;
        logic                      req_seen;
        logic [`SRBM_CNT_W-1:0]    hold_cnt;
        logic [`SRBM_CNT_W-1:0]    test_cnt;
        logic                      test_due;
        logic                      bat_low;
        logic                      rst_low;
        logic                      fail_n;
        logic                      test_pulse;
    } srbm_state_t;

    srbm_state_t st_ff;
    srbm_state_t nxt_st;

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic rstreq_s;
    logic sense_s;
    logic supply_s;
    logic bat_s;

    // supply reads absent until real samples arrive, so no test uses reset values
    srbm_sync u_sync_rst (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_val(1'b1),
        .d      (external_reset_request_n),
        .q      (rstreq_s)
    );
    srbm_sync u_sync_sense (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_val(1'b1),
        .d      (supply_sense_input),
        .q      (sense_s)
    );
    srbm_sync u_sync_sup (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_val(1'b0),
        .d      (supply_above_deselect),
        .q      (supply_s)
    );
    srbm_sync u_sync_bat (
        .clk    (clk),
        .arst_n (arst_n),
        .rst_val(1'b1),
        .d      (battery_ok),
        .q      (bat_s)
    );

    always_comb begin
        nxt_st            = st_ff;
        nxt_st.test_pulse = 1'b0;
        // ****************************************
        // reset request glitch filter
        // ****************************************
        if (rstreq_s) begin
            nxt_st.filt_cnt = '0;
        end else if (st_ff.filt_cnt != FILTER_CYC) begin
            nxt_st.filt_cnt = st_ff.filt_cnt + 1'b1;
        end
        if (st_ff.filt_cnt == FILTER_CYC) begin
            nxt_st.req_seen = 1'b1;
        end
        // ****************************************
        // power state
        // ****************************************
        case (st_ff.pwr)
            SRBM_BACKUP: begin
                nxt_st.fail_n  = 1'b0;
                nxt_st.rst_low = 1'b1;
                if (supply_s) begin
                    nxt_st.pwr      = SRBM_RECOVER;
                    nxt_st.hold_cnt = '0;
                    nxt_st.test_cnt = '0;
                    nxt_st.test_due = 1'b1;
                    nxt_st.fail_n   = 1'b1;
                end
            end
            SRBM_RECOVER: begin
                nxt_st.fail_n  = 1'b1;
                nxt_st.rst_low = 1'b1;
                if (cnt_last(st_ff.hold_cnt, RELEASE_CYC)) begin
                    nxt_st.pwr     = SRBM_RUN;
                    nxt_st.rst_low = 1'b0;
                end else begin
                    nxt_st.hold_cnt = cnt_step(st_ff.hold_cnt);
                end
            end
            SRBM_RUN: begin
                nxt_st.fail_n = sense_s;
                if (st_ff.req_seen) begin
                    // external reset: same hold as power-up, timed from release
                    nxt_st.rst_low  = 1'b1;
                    nxt_st.hold_cnt = '0;
                    if (rstreq_s) begin
                        nxt_st.req_seen = 1'b0;
                        nxt_st.pwr      = SRBM_RECOVER;
                        nxt_st.fail_n   = 1'b1;
                    end
                end
            end
            default: begin
                nxt_st.pwr = SRBM_BACKUP;
            end
        endcase
        if (st_ff.pwr != SRBM_RUN && st_ff.req_seen && rstreq_s) begin
            nxt_st.req_seen = 1'b0;
            nxt_st.hold_cnt = '0;
        end
        // ****************************************
        // battery test scheduling
        // ****************************************
        if (st_ff.pwr != SRBM_BACKUP) begin
            if (cnt_last(st_ff.test_cnt, TEST_CYC)) begin
                nxt_st.test_cnt = '0;
                nxt_st.test_due = 1'b1;
            end else begin
                nxt_st.test_cnt = cnt_step(st_ff.test_cnt);
            end
            if (st_ff.test_due) begin
                nxt_st.test_due   = 1'b0;
                nxt_st.test_pulse = 1'b1;
                nxt_st.bat_low    = !bat_s;
            end
        end
        if (!supply_s) begin
            nxt_st.pwr      = SRBM_BACKUP;
            nxt_st.fail_n   = 1'b0;
            nxt_st.rst_low  = 1'b1;
            nxt_st.test_due = 1'b0;
            nxt_st.test_pulse = 1'b0;
            nxt_st.bat_low  = st_ff.bat_low;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff <= '{pwr: SRBM_BACKUP, filt_cnt: '0, req_seen: 1'b0,
                       hold_cnt: '0, test_cnt: '0, test_due: 1'b0,
                       bat_low: 1'b0, rst_low: 1'b1, fail_n: 1'b0,
                       test_pulse: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    always_comb begin
        reset_out_n_o         = 1'b0;
        reset_out_n_oe        = st_ff.rst_low;
        battery_low_flag_n_o  = 1'b0;
        battery_low_flag_n_oe = st_ff.bat_low;
        supply_fail_output_n  = st_ff.fail_n;
        battery_test_pulse    = st_ff.test_pulse;
    end
endmodule : srbm_top
`default_nettype wire

// ### testbench/srbm_asserts.sv
// assertions for the supervisor reset and battery monitor
`default_nettype none
`include "srbm_consts.svh"
module srbm_asserts #(
    parameter logic [`SRBM_CNT_W-1:0] RELEASE_CYC = 48'h32,
    parameter logic [`SRBM_CNT_W-1:0] TEST_CYC    = 48'hc8
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic external_reset_request_n,
    input wire logic supply_sense_input,
    input wire logic supply_above_deselect,
    input wire logic battery_ok,
    input wire logic reset_out_n_o,
    input wire logic reset_out_n_oe,
    input wire logic battery_low_flag_n_o,
    input wire logic battery_low_flag_n_oe,
    input wire logic supply_fail_output_n,
    input wire logic battery_test_pulse
);
    logic [47:0] quiet_ff;
    logic [15:0] lo_ff;
    logic [15:0] lo_last_ff;
    logic [47:0] gap_ff;
    // cycles since last reset cause; length of last request low run; cycles since last test
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            quiet_ff   <= '0;
            lo_ff      <= '0;
            lo_last_ff <= '0;
            gap_ff     <= '0;
        end else begin
            gap_ff     <= !supply_above_deselect ? '0 : (battery_test_pulse ? 48'h1 : gap_ff + 1);
            quiet_ff   <= (external_reset_request_n && supply_above_deselect) ? quiet_ff + 1 : '0;
            lo_ff      <= external_reset_request_n ? '0 : lo_ff + 1;
            lo_last_ff <= (external_reset_request_n && lo_ff != 0) ? lo_ff : lo_last_ff;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    no_test_backup_a: assert property (!supply_above_deselect[*6] |-> !battery_test_pulse)
        else $error("battery test while on backup");
    low_flag_only_a: assert property ($changed(battery_low_flag_n_oe) |->
        battery_test_pulse || $past(battery_test_pulse)) else $error("flag moved without test");
    low_flag_set_a: assert property (!battery_ok[*4] ##0 battery_test_pulse |->
        ##[0:1] battery_low_flag_n_oe) else $error("weak battery not flagged");
    low_flag_clear_a: assert property (battery_ok[*4] ##0 battery_test_pulse |->
        ##[0:1] !battery_low_flag_n_oe) else $error("good battery still flagged");
    backup_outputs_a: assert property (!supply_above_deselect[*5] |->
        !supply_fail_output_n && reset_out_n_oe) else $error("backup outputs wrong");
    recover_fail_high_a: assert property ($rose(supply_above_deselect) ##1
        supply_above_deselect[*8] |-> supply_fail_output_n) else $error("fail low in recovery");
    reset_hold_a: assert property ($fell(reset_out_n_oe) |-> quiet_ff >= RELEASE_CYC &&
        quiet_ff <= RELEASE_CYC + 8) else $error("reset hold length wrong");
    glitch_filter_a: assert property (supply_above_deselect[*8] ##0 $rose(reset_out_n_oe) |->
        (lo_ff >= `SRBM_FILTER_CYC || lo_last_ff >= `SRBM_FILTER_CYC))
        else $error("short pulse reset");
    sense_track_a: assert property ((!reset_out_n_oe && !supply_sense_input)[*5] |->
        !supply_fail_output_n) else $error("fail output not tracking sense");
    test_spacing_a: assert property (battery_test_pulse |->
        gap_ff == TEST_CYC || gap_ff <= 8) else $error("battery test spacing wrong");
    cover property ($fell(reset_out_n_oe));
    cover property (battery_test_pulse && !battery_ok);
    cover property ($fell(supply_fail_output_n) && supply_above_deselect);
endmodule : srbm_asserts
bind srbm_top srbm_asserts #(.RELEASE_CYC(RELEASE_CYC), .TEST_CYC(TEST_CYC)) i_srbm_asserts (
    .clk(clk), .arst_n(arst_n), .external_reset_request_n(external_reset_request_n),
    .supply_sense_input(supply_sense_input), .supply_above_deselect(supply_above_deselect),
    .battery_ok(battery_ok), .reset_out_n_o(reset_out_n_o), .reset_out_n_oe(reset_out_n_oe),
    .battery_low_flag_n_o(battery_low_flag_n_o), .battery_low_flag_n_oe(battery_low_flag_n_oe),
    .supply_fail_output_n(supply_fail_output_n), .battery_test_pulse(battery_test_pulse));
`default_nettype wire

// ### testbench/srbm_host.sv
// host side: pulled-up open-drain wires and reset request button
`default_nettype none
module srbm_host (
    input  wire logic clk,
    input  wire logic rst_o,
    input  wire logic rst_oe,
    input  wire logic bl_o,
    input  wire logic bl_oe,
    output var  logic rst_wire,
    output var  logic bl_wire,
    output var  logic req_n
);
    timeunit 1ns;
    timeprecision 1ps;
    assign rst_wire = rst_oe ? rst_o : 1'b1;
    assign bl_wire  = bl_oe ? bl_o : 1'b1;
    initial req_n = 1'b1;
    task automatic press(input int n);
        @(posedge clk);
        #1 req_n = 1'b0;
        repeat (n) @(posedge clk);
        #1 req_n = 1'b1;
    endtask : press
endmodule : srbm_host
`default_nettype wire

// ### testbench/test_supervisor_reset_battery_monitor.sv
// testbench for the supervisor reset and battery monitor
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((e) !== (a)) begin err_count++; \
    $display("wrong value %s expected %0h seen %0h", n, e, a); end end
module test_supervisor_reset_battery_monitor;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int REL = 50;
    localparam int TST = 200;
    logic clk, arst_n, sense, sup, bat_ok, rst_o, rst_oe, bl_o, bl_oe, fail_n, tp;
    logic rst_w, bl_w, req_n;
    int   err_count, compares, n, p;
    srbm_top #(.RELEASE_CYC(48'(REL)), .TEST_CYC(48'(TST))) i_srbm_top (
        .clk(clk), .arst_n(arst_n), .external_reset_request_n(req_n),
        .supply_sense_input(sense), .supply_above_deselect(sup), .battery_ok(bat_ok),
        .reset_out_n_o(rst_o), .reset_out_n_oe(rst_oe), .battery_low_flag_n_o(bl_o),
        .battery_low_flag_n_oe(bl_oe), .supply_fail_output_n(fail_n), .battery_test_pulse(tp));
    srbm_host i_srbm_host (.clk(clk), .rst_o(rst_o), .rst_oe(rst_oe), .bl_o(bl_o),
        .bl_oe(bl_oe), .rst_wire(rst_w), .bl_wire(bl_w), .req_n(req_n));
    function automatic logic hold_ok(int c);
        return c >= REL && c <= REL + 8;
    endfunction : hold_ok
    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic cyc(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wait_rst(output int c);
        c = 0;
        while (rst_w !== 1'b1) begin
            cyc(1);
            c++;
            if (c > 400) begin err_count++; finish_test(); end
        end
    endtask : wait_rst
    task automatic count_tp(int k, output int q);
        q = 0;
        repeat (k) begin cyc(1); q += int'(tp === 1'b1); end
    endtask : count_tp
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        void'($urandom(32'h359e2790));
        {arst_n, sense, bat_ok, sup, err_count, compares} = '0;
        sup = 1'b1;
        repeat (12) @(posedge clk);
        #1 arst_n = 1'b1;
        count_tp(20, p);
        `CHK("power-up tests", 1, p)
        `CHK("fail in recovery", 1'b1, fail_n)
        `CHK("battery low", 1'b0, bl_w)
        wait_rst(n);
        `CHK("power-up hold", 1'b1, hold_ok(n + 20))
        bat_ok = 1'b1;
        `CHK("battery low kept", 1'b0, bl_w)
        count_tp(2 * TST + 10, p);
        `CHK("periodic tests", 2, p)
        `CHK("battery low cleared", 1'b1, bl_w)
        $display("test battery done");
        for (int k = 0; k < 9; k++) begin
            i_srbm_host.press(k == 8 ? 24 : 1 + $urandom_range(0, 22));
            cyc(4);
            `CHK("glitch ignored", 1'b1, rst_w)
        end
        i_srbm_host.press(50);
        `CHK("request reset", 1'b0, rst_w)
        wait_rst(n);
        `CHK("request hold", 1'b1, hold_ok(n))
        $display("test reset request done");
        repeat (20) begin
            sense = 1'($urandom);
            cyc(5);
            `CHK("fail tracks sense", sense, fail_n)
        end
        $display("test sense done");
        sup = 1'b0;
        cyc(6);
        `CHK("backup fail", 1'b0, fail_n)
        `CHK("backup reset", 1'b0, rst_w)
        count_tp(TST + 20, p);
        `CHK("backup tests", 0, p)
        sup = 1'b1;
        sense = 1'b0;
        count_tp(20, p);
        `CHK("return test", 1, p)
        `CHK("return fail", 1'b1, fail_n)
        wait_rst(n);
        `CHK("return hold", 1'b1, hold_ok(n + 20))
        cyc(5);
        `CHK("fail after recovery", 1'b0, fail_n)
        count_tp(TST - 35 - n, p);
        `CHK("timer restart quiet", 0, p)
        count_tp(20, p);
        `CHK("timer restart test", 1, p)
        $display("test backup done");
        finish_test();
    end
endmodule : test_supervisor_reset_battery_monitor
`default_nettype wire
